/* File: pms_port0_mode.v */
// Port 0 pin mode select with AXI4-Lite register access
// Behaviour
// - High byte at e0 in bank 1 holds modes of pins 7..4, resets zero.
// - Low byte at e1 in bank 1 holds modes of pins 3..0, resets zero.
// - Mode 00 is Schmitt input; mode 11 is push-pull output from port data.
// - Mode bytes answer only with bank 1 selected, direct register access.
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "pms_map.vh"
module pms_port0_mode (
  input wire aclk,
  input wire aresetn,
  input wire [`PMS_ADDR_W-1:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [`PMS_ADDR_W-1:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [7:0] port_data,
  input wire [7:0] pin_in,
  input wire timer_a_output,
  input wire timer_b_output,
  input wire timer2_output,
  input wire buzzer_output,
  output reg [7:0] pin_out,
  output reg [7:0] pin_oe,
  output reg [7:0] schmitt_en,
  output reg [7:0] analog_en,
  output reg [7:0] pin_sample,
  output reg analog_in_7,
  output reg analog_in_6,
  output reg analog_in_3,
  output reg analog_in_2,
  output reg analog_in_1,
  output reg analog_in_0
);
  // ****************************************
  // Registers and address decode
  // ****************************************
  reg [7:0] port0_mode_high;
  reg [7:0] port0_mode_low;
  reg bank_sel;
  reg [`PMS_ADDR_W-1:0] aw_addr;
  reg aw_held;
  reg [7:0] w_data;
  reg w_held;
  wire [15:0] modes = {port0_mode_high, port0_mode_low};
  wire [7:0] alt_src = {timer_a_output, timer_b_output, 1'b0, 1'b0,
                        timer2_output, 1'b0, 1'b0, buzzer_output};
  // Pins 5, 4, 2 and 1 have no alternative output
  localparam [7:0] ALT_OUT_PINS = 8'hc9;

  // Bank select bit; the mode bytes hide behind it
  // Each register owns one aligned word, so its number is the word index
  function [1:0] decode;
    input [`PMS_ADDR_W-1:0] addr;
    input bank;
    begin
      decode = 2'b00;
      if (addr == {`PMS_OFF_BANK, `PMS_ADDR_LSB})
        decode = 2'b11;
      else if (bank && addr == {`PMS_OFF_MODE_HIGH, `PMS_ADDR_LSB})
        decode = 2'b01;
      else if (bank && addr == {`PMS_OFF_MODE_LOW, `PMS_ADDR_LSB})
        decode = 2'b10;
    end
  endfunction

  wire [`PMS_ADDR_W-1:0] waddr = s_axi_awvalid && !aw_held ? s_axi_awaddr :
                                 aw_addr;
  wire [7:0] wdat = s_axi_wvalid && !w_held ? s_axi_wdata[7:0] : w_data;
  wire have_aw = aw_held || (s_axi_awvalid && s_axi_awready);
  wire have_w = w_held || (s_axi_wvalid && s_axi_wready);
  wire do_write = have_aw && have_w && !s_axi_bvalid;
  wire [1:0] wsel = decode(waddr, bank_sel);
  wire wlane = s_axi_wvalid && !w_held ? s_axi_wstrb[0] : 1'b1;
  reg wlane_held;
  wire wl = w_held ? wlane_held : wlane;

  // ****************************************
  // Write channel
  // ****************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PMS_RESP_OKAY;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= {`PMS_ADDR_W{1'b0}};
      w_data <= 8'h00;
      wlane_held <= 1'b0;
      port0_mode_high <= `PMS_MODE_RESET;
      port0_mode_low <= `PMS_MODE_RESET;
      bank_sel <= `PMS_BANK_RESET;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !w_held && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata[7:0];
        wlane_held <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wsel == 2'b00 ? `PMS_RESP_SLVERR : `PMS_RESP_OKAY;
        if (wl && wsel == 2'b01)
          port0_mode_high <= wdat;
        if (wl && wsel == 2'b10)
          port0_mode_low <= wdat;
        if (wl && wsel == 2'b11)
          bank_sel <= wdat[0];
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // Read channel
  // ****************************************
  wire [1:0] rsel = decode(s_axi_araddr, bank_sel);
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= `PMS_ZERO32;
      s_axi_rresp <= `PMS_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= rsel == 2'b00 ? `PMS_RESP_SLVERR : `PMS_RESP_OKAY;
        case (rsel)
          2'b01: s_axi_rdata <= {24'h000000, port0_mode_high};
          2'b10: s_axi_rdata <= {24'h000000, port0_mode_low};
          2'b11: s_axi_rdata <= {31'h00000000, bank_sel};
          default: s_axi_rdata <= `PMS_ZERO32;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // Pin mode decode
  // ****************************************
  reg [7:0] next_out;
  reg [7:0] next_oe;
  reg [7:0] next_schmitt;
  reg [7:0] next_analog;
  integer i;
  always @* begin
    next_out = 8'h00;
    next_oe = 8'h00;
    next_schmitt = 8'h00;
    next_analog = 8'h00;
    for (i = 0; i < 8; i = i + 1) begin
      case (modes[2*i +: 2])
        `PMS_MODE_INPUT: next_schmitt[i] = 1'b1;
        `PMS_MODE_ALT: begin
          if (ALT_OUT_PINS[i]) begin
            next_out[i] = alt_src[i];
            next_oe[i] = 1'b1;
          end else begin
            next_schmitt[i] = 1'b1;
          end
        end
        `PMS_MODE_ANALOG: next_analog[i] = 1'b1;
        `PMS_MODE_OUTPUT: begin
          next_out[i] = port_data[i];
          next_oe[i] = 1'b1;
        end
        default: next_schmitt[i] = 1'b1;
      endcase
    end
  end

  // Registered outputs cost one cycle of latency on every pin path
  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_out <= 8'h00;
      pin_oe <= 8'h00;
      schmitt_en <= 8'h00;
      analog_en <= 8'h00;
      pin_sample <= 8'h00;
      {analog_in_7, analog_in_6, analog_in_3} <= 3'b000;
      {analog_in_2, analog_in_1, analog_in_0} <= 3'b000;
    end else begin
      pin_out <= next_out;
      pin_oe <= next_oe;
      schmitt_en <= next_schmitt;
      analog_en <= next_analog;
      pin_sample <= pin_in & next_schmitt;
      analog_in_7 <= pin_in[7] & next_analog[7];
      analog_in_6 <= pin_in[6] & next_analog[6];
      analog_in_3 <= pin_in[3] & next_analog[3];
      analog_in_2 <= pin_in[2] & next_analog[2];
      analog_in_1 <= pin_in[1] & next_analog[1];
      analog_in_0 <= pin_in[0] & next_analog[0];
    end
  end
endmodule

/* File: pms_map.vh */
// Register map and field constants for the port 0 pin mode select block
`ifndef PMS_MAP_VH
`define PMS_MAP_VH
`define PMS_ADDR_W 10
`define PMS_ADDR_LSB 2'b00
`define PMS_OFF_MODE_HIGH 8'he0
`define PMS_OFF_MODE_LOW 8'he1
`define PMS_OFF_BANK 8'hfc
`define PMS_MODE_RESET 8'h00
`define PMS_BANK_RESET 1'b0
`define PMS_MODE_INPUT 2'b00
`define PMS_MODE_ALT 2'b01
`define PMS_MODE_ANALOG 2'b10
`define PMS_MODE_OUTPUT 2'b11
`define PMS_RESP_OKAY 2'b00
`define PMS_RESP_SLVERR 2'b10
`define PMS_ZERO32 32'h00000000
`endif

/* File: pms_pin_side.sv */
// Pin side model: resolves each pin from the driver and a far-end pattern
`timescale 1ns/1ps
// ****
// Pins
// ****
module pms_pin_side (
  input wire aclk,
  input wire [7:0] pin_out,
  input wire [7:0] pin_oe,
  output wire [7:0] pin_in
);
  logic [7:0] pat = 8'h00;
  // Undriven pins follow a counter that steps every cycle; only pin 0 toggles each cycle
  always @(posedge aclk) pat <= pat + 8'h01;
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & pat);
endmodule

/* File: pms_checker_assertions.sv */
// Concurrent checks on the pin mode select ports
`timescale 1ns/1ps
// ****
// Checker
// ****
module pms_checker (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] pin_oe,
  input wire [7:0] schmitt_en,
  input wire [7:0] analog_en,
  input wire [7:0] pin_out,
  input wire [7:0] port_data,
  input wire [7:0] pin_in,
  input wire [7:0] pin_sample,
  input wire analog_in_7,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_oe_vs_input: assert property ((pin_oe & schmitt_en) == 8'h00)
    else $error("driver on in input mode");
  a_oe_vs_analog: assert property ((pin_oe & analog_en) == 8'h00)
    else $error("driver on in analog mode");
  a_analog_copy: assert property (
    analog_en[7] |-> analog_in_7 == $past(pin_in[7]))
    else $error("analog channel not pin level");
  a_analog_zero: assert property (!analog_en[7] |-> !analog_in_7)
    else $error("analog channel live outside mode");
  a_pin1_drive: assert property (
    pin_oe[1] |-> pin_out[1] == $past(port_data[1]))
    else $error("pin 1 drive not from port data");
  a_sample_mask: assert property (
    pin_sample == ($past(pin_in) & schmitt_en))
    else $error("input sample mask wrong");
  a_resp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
endmodule
bind pms_port0_mode pms_checker chk_i (.*);

/* File: port0_pin_mode_select_tb.sv */
// Register and pin mode tests for the port 0 pin mode select block
`timescale 1ns/1ps
`include "pms_map.vh"
// ****
// Bench
// ****
module port0_pin_mode_select_tb;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, timer_a_output = 0, timer_b_output = 0;
  logic timer2_output = 0, buzzer_output = 0, analog_in_7, analog_in_6;
  logic analog_in_3, analog_in_2, analog_in_1, analog_in_0;
  logic [`PMS_ADDR_W-1:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [7:0] port_data = 0;
  logic [7:0] pin_in, pin_out, pin_oe, schmitt_en, analog_en, pin_sample;
  logic [7:0] v, src, pin_prev;
  logic [5:0] adc_seen;
  logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
  logic [3:0] s_axi_wstrb = 0;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  // Byte address is four times the register number
  localparam logic [`PMS_ADDR_W-1:0] adr_high = {`PMS_OFF_MODE_HIGH,
                                                 `PMS_ADDR_LSB};
  localparam logic [`PMS_ADDR_W-1:0] adr_low = {`PMS_OFF_MODE_LOW,
                                                `PMS_ADDR_LSB};
  localparam logic [`PMS_ADDR_W-1:0] adr_bank = {`PMS_OFF_BANK,
                                                 `PMS_ADDR_LSB};
  int num_errors = 0, check_count = 0;
  logic [7:0] oe_t[4] = '{8'h00, 8'hc9, 8'h00, 8'hff};
  logic [7:0] sm_t[4] = '{8'hff, 8'h36, 8'h00, 8'h00};
  pms_port0_mode dut (.*);
  pms_pin_side pins (.*);
  always #50 aclk = ~aclk;
  // Pin level one edge back, as the registered outputs see it
  always @(posedge aclk) pin_prev <= pin_in;
  assign adc_seen = {analog_in_7, analog_in_6, analog_in_3, analog_in_2,
                     analog_in_1, analog_in_0};
  task chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      num_errors++;
      $display("unexpected %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // Both channels offered at once, each dropped at its own handshake
  task wr(input logic [`PMS_ADDR_W-1:0] a, input logic [7:0] d,
          input logic [3:0] s, input logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid || s_axi_wvalid);
    while (!s_axi_bvalid) @(posedge aclk);
    chk(s_axi_bresp, r);
    s_axi_bready <= 1'b0;
  endtask
  task rd(input logic [`PMS_ADDR_W-1:0] a, input logic [31:0] e,
          input logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    chk(s_axi_rdata, e);
    chk(s_axi_rresp, r);
    s_axi_rready <= 1'b0;
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #200000;
    num_errors++;
    complete_run;
  end
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(adr_high, 0, `PMS_RESP_SLVERR);
    wr(adr_low, 8'hff, 4'h1, `PMS_RESP_SLVERR);
    wr(adr_bank, 8'h01, 4'hf, `PMS_RESP_OKAY);
    rd(adr_high, 0, `PMS_RESP_OKAY);
    rd(adr_low, 0, `PMS_RESP_OKAY);
    rd(10'h040, 0, `PMS_RESP_SLVERR);
    $display("reset and bank test done");
    for (int i = 0; i < 4; i++) begin
      v = {4{i[1:0]}};
      port_data <= 8'h5a ^ {8{i[1]}};
      {timer_a_output, timer_b_output, timer2_output, buzzer_output} <= 4'hb;
      wr(adr_high, v, 4'h1, `PMS_RESP_OKAY);
      wr(adr_low, v, 4'h1, `PMS_RESP_OKAY);
      rd(adr_high, v, `PMS_RESP_OKAY);
      rd(adr_low, v, `PMS_RESP_OKAY);
      @(posedge aclk);
      src = (i == 3) ? port_data : 8'b10001011;
      chk(pin_oe, oe_t[i]);
      chk(schmitt_en, sm_t[i]);
      chk(analog_en, {8{i == 2}});
      chk(pin_out & pin_oe, src & oe_t[i]);
      chk(pin_sample, pin_prev & sm_t[i]);
      chk(adc_seen, {pin_prev[7:6], pin_prev[3:0]} & {6{i == 2}});
      $display("mode code %0d done", i);
    end
    wr(adr_high, 8'h00, 4'h0, `PMS_RESP_OKAY);
    rd(adr_high, 8'hff, `PMS_RESP_OKAY);
    wr(adr_bank, 8'h00, 4'hf, `PMS_RESP_OKAY);
    wr(adr_low, 8'h00, 4'h1, `PMS_RESP_SLVERR);
    wr(adr_bank, 8'h01, 4'hf, `PMS_RESP_OKAY);
    rd(adr_low, 8'hff, `PMS_RESP_OKAY);
    $display("bank and strobe test done");
    complete_run;
  end
endmodule
